// ===== src/incremental_encoder_counter.v
/*
  Quadrature encoder counter with totalizing, angle and speed output modes,
  reached over a plain address/strobe register port.
  Assumes encoder phases are synchronous to CLK and change at most once
  per clock edge pair; one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "enc_counter_map.vh"

module incremental_encoder_counter #(
  parameter COUNT_WIDTH = 32,
  parameter [31:0] GATE_10MS_CYCLES = `GATE_10MS_US * `CLK_MHZ,
  parameter [31:0] GATE_100MS_CYCLES = `GATE_100MS_US * `CLK_MHZ,
  parameter [31:0] GATE_1S_CYCLES = `GATE_1S_US * `CLK_MHZ
) (
  input wire CLK,
  input wire RESET,
  input wire PHASE_FIRST,
  input wire PHASE_SECOND,
  input wire TARE,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  output reg [31:0] OUTPUT_VALUE,
  output reg WINDOW_DONE
);

////////////////////////////////////////////////////////////////////////////////
// Input sampling and quadrature decode

// Transition codes {previous, current} of the {first, second} phase pair
localparam [3:0] UP_00_10 = 4'h2;
localparam [3:0] UP_10_11 = 4'hb;
localparam [3:0] UP_11_01 = 4'hd;
localparam [3:0] UP_01_00 = 4'h4;
localparam [3:0] DN_00_01 = 4'h1;
localparam [3:0] DN_01_11 = 4'h7;
localparam [3:0] DN_11_10 = 4'he;
localparam [3:0] DN_10_00 = 4'h8;

reg [1:0] phase_prev;
reg primed;
wire [1:0] phase_now = {PHASE_FIRST, PHASE_SECOND};
reg step_valid;
reg step_up;

always @(posedge CLK) begin
  if (RESET) begin
    phase_prev <= 2'h0;
    primed <= 1'b0;
  end else begin
    phase_prev <= phase_now;
    primed <= 1'b1;
  end
end

// Gray sequence 00-10-11-01 counts up when the first phase leads
always @* begin
  step_valid = 1'b0;
  step_up = 1'b0;
  case ({phase_prev, phase_now})
    UP_00_10, UP_10_11, UP_11_01, UP_01_00: begin
      step_valid = 1'b1;
      step_up = 1'b1;
    end
    DN_00_01, DN_01_11, DN_11_10, DN_10_00: begin
      step_valid = 1'b1;
      step_up = 1'b0;
    end
    default: begin
      // No change, or both phases moved at once: ambiguous, not counted
      step_valid = 1'b0;
      step_up = 1'b0;
    end
  endcase
  // The first sample after reset only loads the history: the encoder may
  // rest in any state, and a mismatch with the reset value is not an edge
  if (!primed) begin
    step_valid = 1'b0;
    step_up = 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registers

// CONTROL holds the mode in [1:0] and the gate window in [3:2]; a one
// written to bit 4 tares. Mode 3 falls back to totalizing and gate code 3
// to the longest window, so no code leaves the output undefined.
// PULSES_PER_REV sets the angle modulus; zero holds the angle at zero.
// POSITION and OUTPUT_VALUE are read-only views; STATUS shows the last
// sampled phase pair, which helps when wiring an encoder up.
reg [31:0] control;
reg [31:0] pulses_per_rev;
wire [1:0] mode = control[`CTRL_MODE_HI:`CTRL_MODE_LO];
wire [1:0] gate_sel = control[`CTRL_GATE_HI:`CTRL_GATE_LO];
wire soft_tare = WR && (ADDR == `REG_CONTROL) && WDATA[`CTRL_TARE_BIT];
wire tare_req = TARE || soft_tare;

always @(posedge CLK) begin
  if (RESET) begin
    control <= `CONTROL_RESET;
    pulses_per_rev <= `PPR_RESET;
  end else if (WR) begin
    if (ADDR == `REG_CONTROL) begin
      // Tare bit is a self-clearing command, not stored
      control <= {28'h0000000, WDATA[`CTRL_GATE_HI:`CTRL_MODE_LO]};
    end
    if (ADDR == `REG_PULSES_PER_REV) begin
      pulses_per_rev <= WDATA;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Position counter

reg [COUNT_WIDTH-1:0] position;
reg [COUNT_WIDTH-1:0] next_position;

always @* begin
  next_position = position;
  // Tare wins over a step in the same cycle
  if (tare_req) begin
    next_position = {COUNT_WIDTH{1'b0}};
  end else if (step_valid && step_up) begin
    // Plain modular add wraps +max to the most negative count
    next_position = position + 1'b1;
  end else if (step_valid) begin
    next_position = position - 1'b1;
  end
end

always @(posedge CLK) begin
  if (RESET) begin
    position <= {COUNT_WIDTH{1'b0}};
  end else begin
    position <= next_position;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Angle tracking

// Kept in step with the counter so no divider is needed; a change of the
// pulses-per-revolution value takes effect at the next step, without a tare
reg [31:0] angle;
reg [31:0] next_angle;
wire [31:0] ppr_last = (pulses_per_rev == 32'h00000000) ? 32'h00000000 :
  pulses_per_rev - 32'h00000001;

always @* begin
  next_angle = angle;
  if (tare_req) begin
    next_angle = 32'h00000000;
  end else if (step_valid && step_up) begin
    next_angle = (angle >= ppr_last) ? 32'h00000000 : angle + 32'h00000001;
  end else if (step_valid) begin
    next_angle = (angle == 32'h00000000 || angle > ppr_last) ? ppr_last :
      angle - 32'h00000001;
  end
end

always @(posedge CLK) begin
  if (RESET) begin
    angle <= 32'h00000000;
  end else begin
    angle <= next_angle;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Speed gate window

// Speed is the signed net step count, so a reversing shaft reads negative;
// the window free-runs in every mode and restarts on tare
reg [31:0] gate_count;
reg [31:0] window_pulses;
reg [31:0] speed;
reg [31:0] gate_len;
wire gate_end = (gate_count >= gate_len - 32'h00000001);

always @* begin
  case (gate_sel)
    `GATE_10MS: begin
      gate_len = GATE_10MS_CYCLES;
    end
    `GATE_100MS: begin
      gate_len = GATE_100MS_CYCLES;
    end
    `GATE_1S: begin
      gate_len = GATE_1S_CYCLES;
    end
    default: begin
      // Code 3 is unassigned; the longest window is the safe reading
      gate_len = GATE_1S_CYCLES;
    end
  endcase
end

always @(posedge CLK) begin
  if (RESET) begin
    gate_count <= 32'h00000000;
    window_pulses <= 32'h00000000;
    speed <= 32'h00000000;
    WINDOW_DONE <= 1'b0;
  end else begin
    WINDOW_DONE <= gate_end;
    if (tare_req) begin
      gate_count <= 32'h00000000;
      window_pulses <= 32'h00000000;
      speed <= 32'h00000000;
    end else if (gate_end) begin
      gate_count <= 32'h00000000;
      // The step in the closing cycle belongs to this window
      if (step_valid && step_up) begin
        speed <= window_pulses + 32'h00000001;
      end else if (step_valid) begin
        speed <= window_pulses - 32'h00000001;
      end else begin
        speed <= window_pulses;
      end
      window_pulses <= 32'h00000000;
    end else begin
      gate_count <= gate_count + 32'h00000001;
      if (step_valid && step_up) begin
        window_pulses <= window_pulses + 32'h00000001;
      end else if (step_valid) begin
        window_pulses <= window_pulses - 32'h00000001;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output selection

// One cycle behind its sources so the output is a plain flip-flop
always @(posedge CLK) begin
  if (RESET) begin
    OUTPUT_VALUE <= 32'h00000000;
  end else begin
    case (mode)
      `MODE_TOTAL: begin
        OUTPUT_VALUE <= position;
      end
      `MODE_ANGLE: begin
        OUTPUT_VALUE <= angle;
      end
      `MODE_SPEED: begin
        OUTPUT_VALUE <= speed;
      end
      default: begin
        OUTPUT_VALUE <= position;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read port

// Idle cycles read zero so a stale word is never taken for an answer
always @(posedge CLK) begin
  if (RESET) begin
    RDATA <= 32'h00000000;
  end else if (RD) begin
    case (ADDR)
      `REG_CONTROL: begin
        RDATA <= control;
      end
      `REG_PULSES_PER_REV: begin
        RDATA <= pulses_per_rev;
      end
      `REG_POSITION: begin
        RDATA <= position;
      end
      `REG_OUTPUT_VALUE: begin
        RDATA <= OUTPUT_VALUE;
      end
      `REG_STATUS: begin
        RDATA <= {30'h0, phase_prev};
      end
      default: begin
        RDATA <= 32'h00000000;
      end
    endcase
  end else begin
    RDATA <= 32'h00000000;
  end
end

endmodule // incremental_encoder_counter

// ===== src/enc_counter_map.vh
/*
  Constants for the incremental encoder counter: register offsets, field
  positions, mode codes, reset values and gate-window times.
  Assumes a 25 MHz system clock and a plain strobe register port.
*/
`ifndef ENC_COUNTER_MAP_VH
`define ENC_COUNTER_MAP_VH

// Register offsets (byte addresses, one 32-bit word each)
`define REG_CONTROL 8'h00
`define REG_PULSES_PER_REV 8'h04
`define REG_POSITION 8'h08
`define REG_OUTPUT_VALUE 8'h0c
`define REG_STATUS 8'h10

// Control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_GATE_LO 2
`define CTRL_GATE_HI 3
`define CTRL_TARE_BIT 4

// Mode codes
`define MODE_TOTAL 2'h0
`define MODE_ANGLE 2'h1
`define MODE_SPEED 2'h2

// Gate window codes
`define GATE_10MS 2'h0
`define GATE_100MS 2'h1
`define GATE_1S 2'h2

// Reset values
`define CONTROL_RESET 32'h00000000
`define PPR_RESET 32'h00000168

// Gate window times in microseconds, system clock in MHz
`define GATE_10MS_US 10000
`define GATE_100MS_US 100000
`define GATE_1S_US 1000000
`define CLK_MHZ 25

`endif

// ===== tb/enc_props.sv
/* Port checker for the encoder counter.
   Bound from the bench; mirrors the mode and pulses-per-rev writes. */
`timescale 1ns/100ps
module enc_props (
  input wire CLK,
  input wire RESET,
  input wire PHASE_FIRST,
  input wire PHASE_SECOND,
  input wire TARE,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire [31:0] OUTPUT_VALUE,
  input wire WINDOW_DONE
);
  reg [1:0] ab;
  reg pr;
  reg [1:0] md;
  reg [31:0] ppr;
  wire [31:0] ov = OUTPUT_VALUE;
  wire [3:0] tr = {ab, PHASE_FIRST, PHASE_SECOND};
  wire q = !TARE && !WR;
  wire up = pr && q && (tr == 4'h2 || tr == 4'hb || tr == 4'hd || tr == 4'h4);
  wire dn = pr && q && (tr == 4'h1 || tr == 4'h7 || tr == 4'he || tr == 4'h8);
  always @(posedge CLK) begin
    if (RESET) begin
      ab <= 2'h0;
      pr <= 1'b0;
      md <= 2'h0;
      ppr <= 32'h168;
    end else begin
      ab <= {PHASE_FIRST, PHASE_SECOND};
      pr <= 1'b1;
      if (WR && ADDR == 8'h00)
        md <= WDATA[1:0];
      if (WR && ADDR == 8'h04)
        ppr <= WDATA;
    end
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);
  tare_clear_a: assert property (TARE && !WR && md != 2'h2 |-> ##2 ov == 32'h0)
    else $error("tare");
  count_up_a: assert property (md == 2'h0 && up |-> ##2 ov == $past(ov) + 32'h1)
    else $error("up");
  count_down_a: assert property (md == 2'h0 && dn |-> ##2 ov == $past(ov) - 32'h1)
    else $error("down");
  still_hold_a: assert property (md != 2'h2 && q && !up && !dn |-> ##2 $stable(ov))
    else $error("hold");
  angle_up_a: assert property (md == 2'h1 && up |-> ##2 ov ==
    ($past(ov) == ppr - 32'h1 || ppr == 32'h0 ? 32'h0 : $past(ov) + 32'h1))
    else $error("angle up");
  angle_down_a: assert property (md == 2'h1 && dn |-> ##2 ov ==
    ($past(ov) == 32'h0 ? (ppr == 32'h0 ? 32'h0 : ppr - 32'h1) : $past(ov) - 32'h1))
    else $error("angle down");
  angle_range_a: assert property (md == 2'h1 && !WR |=> ov < ppr || ov == 32'h0)
    else $error("angle range");
  gate_gap_a: assert property (WINDOW_DONE |=> !WINDOW_DONE [*8])
    else $error("window");
endmodule // enc_props

// ===== tb/quad_encoder.sv
/* Two-phase encoder model.
   One Gray step per step pulse; skip flips both phases on purpose. */
`timescale 1ns/100ps
module quad_encoder (
  input wire clk,
  input wire step,
  input wire dir,
  input wire skip,
  output reg phase_first = 1'b0,
  output reg phase_second = 1'b0
);
  always @(posedge clk) begin
    if (skip) begin
      phase_first <= ~phase_first;
      phase_second <= ~phase_second;
    end else if (step) begin
      phase_first <= dir ? ~phase_second : phase_second;
      phase_second <= dir ? phase_first : ~phase_first;
    end
  end
endmodule // quad_encoder

// ===== tb/tb_incremental_encoder_counter.sv
/* Bench for the encoder counter: counting table, then speed and tare cases.
   Assumes the checker and the encoder model are compiled first. */
`timescale 1ns/100ps
module tb_incremental_encoder_counter;
  reg CLK = 1'b0, RESET = 1'b1, TARE = 1'b0, WR = 1'b0, RD = 1'b0;
  reg step = 1'b0, dir = 1'b0, skip = 1'b0;
  reg [7:0] ADDR = 8'h00;
  reg [31:0] WDATA = 32'h0, gate;
  wire PHASE_FIRST, PHASE_SECOND, WINDOW_DONE;
  wire [31:0] RDATA, OUTPUT_VALUE;
  reg [47:0] rows [0:3];
  integer fail_count = 0, compares = 0, r, g, j;
  always #20 CLK = ~CLK;
  quad_encoder enc_u (.clk(CLK), .step(step), .dir(dir), .skip(skip),
    .phase_first(PHASE_FIRST), .phase_second(PHASE_SECOND));
  // Short gate windows keep the speed cases brief
  incremental_encoder_counter #(.GATE_10MS_CYCLES(32'h14), .GATE_100MS_CYCLES(32'h32),
    .GATE_1S_CYCLES(32'h64)) dut_u (.CLK(CLK), .RESET(RESET), .PHASE_FIRST(PHASE_FIRST),
    .PHASE_SECOND(PHASE_SECOND), .TARE(TARE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .OUTPUT_VALUE(OUTPUT_VALUE), .WINDOW_DONE(WINDOW_DONE));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
      @(posedge CLK);
    end
  endtask
  task look(input [31:0] exp);
    begin
      #1;
      chk(OUTPUT_VALUE, exp);
      @(posedge CLK);
    end
  endtask
  task steps(input integer n, input d);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        step <= 1'b1;
        dir <= d;
        @(posedge CLK);
        step <= 1'b0;
        @(posedge CLK);
      end
      repeat (3) @(posedge CLK);
    end
  endtask
  task wait_win;
    begin
      j = 0;
      do begin
        @(posedge CLK);
        #1;
        j = j + 1;
      end while (WINDOW_DONE !== 1'b1 && j < 300);
      chk({31'h0, WINDOW_DONE}, 32'h1);
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    rows[0] = {8'h10, 7'h05, 1'b1, 32'h5};
    rows[1] = {8'h00, 7'h08, 1'b0, 32'hfffffffd};
    rows[2] = {8'h11, 7'h07, 1'b1, 32'h1};
    rows[3] = {8'h01, 7'h03, 1'b0, 32'h4};
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    rd(8'h04, 32'h168);
    rd(8'h20, 32'h0);
    wr(8'h04, 32'h6);
    for (r = 0; r < 4; r = r + 1) begin
      wr(8'h00, {24'h0, rows[r][47:40]});
      steps(rows[r][39:33], rows[r][32]);
      look(rows[r][31:0]);
    end
    $display("table done");
    for (g = 0; g < 3; g = g + 1) begin
      gate = g == 0 ? 32'h14 : (g == 1 ? 32'h32 : 32'h64);
      fork
        steps(gate + 10, 1'b1);
        begin
          wr(8'h00, {28'h1, g[1:0], 2'h2});
          wait_win;
          wait_win;
          chk(OUTPUT_VALUE, gate >> 1);
          @(posedge CLK);
        end
      join
    end
    $display("speed done");
    wr(8'h00, 32'h10);
    steps(4, 1'b1);
    TARE <= 1'b1;
    @(posedge CLK);
    TARE <= 1'b0;
    steps(2, 1'b0);
    look(32'hfffffffe);
    rd(8'h08, 32'hfffffffe);
    skip <= 1'b1;
    @(posedge CLK);
    skip <= 1'b0;
    steps(1, 1'b1);
    look(32'hffffffff);
    $display("tare done");
    wr(8'h00, 32'h1f);
    wait_win;
    chk(j, 32'h64);
    @(posedge CLK);
    steps(4, 1'b1);
    look(32'h4);
    $display("spare codes done");
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    rd(8'h00, 32'h0);
    look(32'h0);
    rd(8'h04, 32'h168);
    $display("reset done");
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge CLK);
    fail_count = fail_count + 1;
    wrap_up;
  end
endmodule // tb_incremental_encoder_counter
bind incremental_encoder_counter enc_props chk_u (.CLK(CLK), .RESET(RESET),
  .PHASE_FIRST(PHASE_FIRST), .PHASE_SECOND(PHASE_SECOND), .TARE(TARE), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OUTPUT_VALUE(OUTPUT_VALUE),
  .WINDOW_DONE(WINDOW_DONE));
